// file: wdu_top.sv
// Purpose: Word integer divide unit, legacy signed, signed and unsigned
// Assumes: Issue logic may issue while BUSY_OUT is high; the unit ignores such an issue
// Notes:   Outputs are registered; write enables pulse one cycle
`timescale 1ns/1ps
module wdu_top (
  input  wire logic        CLK_IN,          // 10 MHz clock
  input  wire logic        SYS_RST_IN,      // Synchronous reset
  input  wire logic        CE_IN,           // Clock enable
  input  wire logic        ISSUE_IN,        // Instruction valid pulse
  input  wire logic [31:0] INSTR_IN,        // Instruction word
  input  wire logic [31:0] SRC1_DATA_IN,    // First source operand
  input  wire logic [31:0] SRC2_DATA_IN,    // Second source operand
  input  wire logic        SO_IN,           // Current summary overflow
  output logic             BUSY_OUT,        // Divide in progress
  output logic             ILLEGAL_OUT,     // Issue not a divide
  output logic             TGT_WE_OUT,      // Target write pulse
  output logic [4:0]       TGT_SEL_OUT,     // Target register field
  output logic [31:0]      TGT_DATA_OUT,    // Quotient
  output logic             REM_WE_OUT,      // Remainder register write
  output logic [31:0]      REM_DATA_OUT,    // Remainder
  output logic             XER_WE_OUT,      // Summary/overflow write
  output logic             SO_OUT,          // New summary overflow
  output logic             OV_OUT,          // New overflow flag
  output logic             CR0_WE_OUT,      // Condition field write
  output logic [3:0]       CR0_OUT          // lt,gt,eq,so
);
  typedef enum logic [1:0] {WDU_IDLE, WDU_RUN, WDU_FIN} wdu_state_e;
  ////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Absolute value of a signed word
  function automatic logic [31:0] wdu_abs(input logic [31:0] v);
    wdu_abs = v[31] ? (wdu_pkg::ZERO_W - v) : v;
  endfunction
  // Negate when asked
  function automatic logic [31:0] wdu_neg(input logic [31:0] v,
                                          input logic        n);
    wdu_neg = n ? (wdu_pkg::ZERO_W - v) : v;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire [5:0] prim   = INSTR_IN[wdu_pkg::PRIM_HI:wdu_pkg::PRIM_LO];
  wire [8:0] ext    = INSTR_IN[wdu_pkg::EXT_HI:wdu_pkg::EXT_LO];
  wire       is_p31 = (prim == wdu_pkg::PRIM_OP);
  wire       dec_leg = is_p31 && (ext == wdu_pkg::EXT_LEGACY);
  wire       dec_sgn = is_p31 && (ext == wdu_pkg::EXT_SIGNED);
  wire       dec_uns = is_p31 && (ext == wdu_pkg::EXT_UNSIGNED);
  wire       dec_any = dec_leg || dec_sgn || dec_uns;
  wire       unsgn   = dec_uns;
  // Overflow screen on the issued operands
  wire       dvs_zero = (SRC2_DATA_IN == wdu_pkg::ZERO_W);
  wire       neg_ovf  = !unsgn && (SRC1_DATA_IN == wdu_pkg::MOST_NEG) &&
                        (SRC2_DATA_IN == wdu_pkg::MINUS_ONE);
  wire       start    = ISSUE_IN && dec_any && !BUSY_OUT;
  // Magnitudes fed to the core
  wire [31:0] mag1 = unsgn ? SRC1_DATA_IN : wdu_abs(SRC1_DATA_IN);
  wire [31:0] mag2 = unsgn ? SRC2_DATA_IN : wdu_abs(SRC2_DATA_IN);
  ////////////////////////////////////////////////////////////////////////
  // Held instruction state
  wdu_state_e           st_r, st_nxt;
  wdu_pkg::wdu_kind_e   kind_r;          // Which divide
  logic [4:0]           tsel_r;          // Target field
  logic                 oe_r;            // Overflow enable
  logic                 rec_r;           // Record bit
  logic                 ovf_r;           // Overflow case
  logic                 mnn_r;           // Most negative by minus one
  logic                 qneg_r;          // Quotient sign
  logic                 rneg_r;          // Remainder sign
  logic                 so_r;            // Summary overflow snapshot
  logic                 core_done;       // Core finished
  logic [31:0]          core_q;          // Core quotient
  logic [31:0]          core_r;          // Core remainder
  ////////////////////////////////////////////////////////////////////////
  // Unsigned core
  wdu_core u_core (
    .clk_in   (CLK_IN),
    .rst_in   (SYS_RST_IN),
    .ce_in    (CE_IN),
    .start_in (start && !dvs_zero && !neg_ovf),
    .dvd_in   (mag1),
    .dvs_in   (mag2),
    .done_out (core_done),
    .quo_out  (core_q),
    .rem_out  (core_r)
  );
  ////////////////////////////////////////////////////////////////////////
  // Result formation
  // Signs restored; zero results stay positive zero
  wire [31:0] q_fin = ovf_r ? (mnn_r ? wdu_pkg::MOST_NEG : wdu_pkg::ZERO_W)
                            : wdu_neg(core_q, qneg_r);
  wire [31:0] r_fin = ovf_r ? wdu_pkg::ZERO_W
                            : wdu_neg(core_r, rneg_r);
  // Overflow flag update, summary sticky
  wire        so_new = ovf_r | so_r;
  wire        so_use = oe_r ? so_new : so_r;
  // Signed compare against zero, unsigned too
  wire        lt_b   = q_fin[31];
  wire        eq_b   = (q_fin == wdu_pkg::ZERO_W);
  wire        gt_b   = !lt_b && !eq_b;
  wire        finish = (st_r == WDU_RUN && core_done) || st_r == WDU_FIN;
  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      WDU_IDLE:
        if (start)
          st_nxt = (dvs_zero || neg_ovf) ? WDU_FIN : WDU_RUN;
      WDU_RUN:
        if (core_done)
          st_nxt = WDU_IDLE;
      WDU_FIN:
        st_nxt = WDU_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // Capture instruction at issue
  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      st_r   <= WDU_IDLE;
      kind_r <= wdu_pkg::WDU_LEGACY;
      tsel_r <= '0;
      oe_r   <= 1'b0;
      rec_r  <= 1'b0;
      ovf_r  <= 1'b0;
      mnn_r  <= 1'b0;
      qneg_r <= 1'b0;
      rneg_r <= 1'b0;
      so_r   <= 1'b0;
    end
    else if (CE_IN)
    begin
      st_r <= st_nxt;
      if (start)
      begin
        // Legacy form treats bit 21 as overflow enable as well
        kind_r <= dec_leg ? wdu_pkg::WDU_LEGACY :
                  dec_sgn ? wdu_pkg::WDU_SIGNED : wdu_pkg::WDU_UNSIGNED;
        tsel_r <= INSTR_IN[wdu_pkg::TGT_HI:wdu_pkg::TGT_LO];
        oe_r   <= INSTR_IN[wdu_pkg::OE_POS];
        rec_r  <= INSTR_IN[wdu_pkg::REC_POS];
        ovf_r  <= dvs_zero || neg_ovf;
        mnn_r  <= neg_ovf && dec_leg;
        qneg_r <= !unsgn && (SRC1_DATA_IN[31] ^ SRC2_DATA_IN[31]);
        rneg_r <= !unsgn && SRC1_DATA_IN[31];
        so_r   <= SO_IN;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      BUSY_OUT     <= 1'b0;
      ILLEGAL_OUT  <= 1'b0;
      TGT_WE_OUT   <= 1'b0;
      TGT_SEL_OUT  <= '0;
      TGT_DATA_OUT <= '0;
      REM_WE_OUT   <= 1'b0;
      REM_DATA_OUT <= '0;
      XER_WE_OUT   <= 1'b0;
      SO_OUT       <= 1'b0;
      OV_OUT       <= 1'b0;
      CR0_WE_OUT   <= 1'b0;
      CR0_OUT      <= '0;
    end
    else if (CE_IN)
    begin
      BUSY_OUT    <= (st_nxt != WDU_IDLE);
      ILLEGAL_OUT <= ISSUE_IN && !dec_any && !BUSY_OUT;
      TGT_WE_OUT  <= finish;
      REM_WE_OUT  <= finish && kind_r == wdu_pkg::WDU_LEGACY;
      XER_WE_OUT  <= finish && oe_r;
      CR0_WE_OUT  <= finish && rec_r;
      if (finish)
      begin
        TGT_SEL_OUT  <= tsel_r;
        TGT_DATA_OUT <= q_fin;
        REM_DATA_OUT <= r_fin;
        OV_OUT       <= ovf_r;
        SO_OUT       <= so_new;
        CR0_OUT      <= {lt_b, gt_b, eq_b, so_use};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Assertions
  // Operand copies kept only for the equation check
  logic [31:0]          chk_dvd_r;       // Dividend in flight
  logic [31:0]          chk_dvs_r;       // Divisor in flight
  // Capture operands when a divide is taken
  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      chk_dvd_r <= '0;
      chk_dvs_r <= '0;
    end
    else if (CE_IN && start)
    begin
      chk_dvd_r <= SRC1_DATA_IN;
      chk_dvs_r <= SRC2_DATA_IN;
    end
  end
  property p_mnn;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (start && dec_leg && neg_ovf && CE_IN) ##1 CE_IN ##1 CE_IN |->
      REM_WE_OUT && REM_DATA_OUT == wdu_pkg::ZERO_W &&
      TGT_DATA_OUT == wdu_pkg::MOST_NEG;
  endproperty
  a_mnn: assert property (p_mnn) else $error("min/-1 result wrong");
  property p_rem_sign;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (REM_WE_OUT && REM_DATA_OUT != wdu_pkg::ZERO_W) |->
      (REM_DATA_OUT[31] == $past(rneg_r));
  endproperty
  a_rem_sign: assert property (p_rem_sign) else $error("rem sign");
  property p_rem_only_leg;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    REM_WE_OUT |-> $past(kind_r) == wdu_pkg::WDU_LEGACY;
  endproperty
  a_rem_only_leg: assert property (p_rem_only_leg)
    else $error("rem write");
  property p_xer_oe;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (XER_WE_OUT && $past(CE_IN)) |->
      $past(oe_r) && $past(finish);
  endproperty
  a_xer_oe: assert property (p_xer_oe) else $error("xer write");
  property p_cr_rec;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    CR0_WE_OUT |-> $past(rec_r) && TGT_WE_OUT;
  endproperty
  a_cr_rec: assert property (p_cr_rec) else $error("cr write");
  property p_zero_ov;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (start && dvs_zero && INSTR_IN[wdu_pkg::OE_POS] && CE_IN)
      ##1 CE_IN ##1 CE_IN |-> XER_WE_OUT && OV_OUT && SO_OUT;
  endproperty
  a_zero_ov: assert property (p_zero_ov) else $error("ov on zero");
  property p_so_copy;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (CR0_WE_OUT && XER_WE_OUT) |-> CR0_OUT[wdu_pkg::CR_SO] == SO_OUT;
  endproperty
  a_so_copy: assert property (p_so_copy) else $error("so copy");
  property p_cr_sign;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    CR0_WE_OUT |-> CR0_OUT[wdu_pkg::CR_LT] == TGT_DATA_OUT[31] &&
      CR0_OUT[wdu_pkg::CR_EQ] == (TGT_DATA_OUT == wdu_pkg::ZERO_W);
  endproperty
  a_cr_sign: assert property (p_cr_sign) else $error("cr sign");
  property p_done_bound;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    ($rose(BUSY_OUT) && CE_IN) |-> ##[1:40] TGT_WE_OUT;
  endproperty
  a_done_bound: assert property (p_done_bound)
    else $error("no result");
  // Results satisfy the division equation
  property p_div_eq;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (TGT_WE_OUT && !ovf_r) |->
      chk_dvd_r == chk_dvs_r * TGT_DATA_OUT + REM_DATA_OUT;
  endproperty
  a_div_eq: assert property (p_div_eq) else $error("equation");
  // One target write per divide
  property p_we_pulse;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (TGT_WE_OUT && CE_IN) |=> !TGT_WE_OUT;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("we pulse");
  // Non-divide issue flagged, never written
  property p_illegal;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (ISSUE_IN && !dec_any && !BUSY_OUT && CE_IN) |=>
      ILLEGAL_OUT && !TGT_WE_OUT;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal");
  c_leg: cover property (@(posedge CLK_IN) REM_WE_OUT);
  c_ovf: cover property (@(posedge CLK_IN) XER_WE_OUT && OV_OUT);
  c_rec: cover property (@(posedge CLK_IN)
    CR0_WE_OUT && CR0_OUT[wdu_pkg::CR_LT]);
  c_hold: cover property (@(posedge CLK_IN) BUSY_OUT && !CE_IN);
  c_refuse: cover property (@(posedge CLK_IN) BUSY_OUT && ISSUE_IN);
endmodule

// file: wdu_pkg.sv
// Purpose: Shared constants for the word integer divide unit
// Assumes: Instruction bit 0 is the most significant bit of the word
// Notes:   Field positions are given in little-endian index form
package wdu_pkg;
  // Operand width
  localparam int WIDTH = 32;
  localparam int CNT_W = 6;
  // Instruction fields, as [msb:lsb] in little-endian numbering
  localparam int PRIM_HI = 31;               // Instruction bits 0-5
  localparam int PRIM_LO = 26;
  localparam int TGT_HI  = 25;               // Instruction bits 6-10
  localparam int TGT_LO  = 21;
  localparam int SRC1_HI = 20;               // Instruction bits 11-15
  localparam int SRC1_LO = 16;
  localparam int SRC2_HI = 15;               // Instruction bits 16-20
  localparam int SRC2_LO = 11;
  localparam int OE_POS  = 10;               // Instruction bit 21
  localparam int EXT_HI  = 9;                // Instruction bits 22-30
  localparam int EXT_LO  = 1;
  localparam int REC_POS = 0;                // Instruction bit 31
  // Opcodes
  localparam logic [5:0] PRIM_OP       = 6'h1F;   // 31
  localparam logic [8:0] EXT_LEGACY    = 9'h16B;  // 363
  localparam logic [8:0] EXT_SIGNED    = 9'h1EB;  // 491
  localparam logic [8:0] EXT_UNSIGNED  = 9'h1CB;  // 459
  // Special values
  localparam logic [31:0] MOST_NEG  = 32'h80000000;
  localparam logic [31:0] MINUS_ONE = 32'hFFFFFFFF;
  localparam logic [31:0] ZERO_W    = 32'h00000000;
  localparam logic [5:0]  STEPS     = 6'h20;      // One bit per cycle
  localparam logic [5:0]  CNT_ONE   = 6'h01;
  // Condition field bit positions, [3:0] = lt,gt,eq,so
  localparam int CR_LT = 3;
  localparam int CR_GT = 2;
  localparam int CR_EQ = 1;
  localparam int CR_SO = 0;
  // Divide kind
  typedef enum logic [1:0] {WDU_LEGACY, WDU_SIGNED, WDU_UNSIGNED} wdu_kind_e;
endpackage

// file: wdu_core.sv
// Purpose: Restoring unsigned 32-bit divider, one quotient bit a cycle
// Assumes: Divisor is nonzero when started; caller screens zero
// Notes:   Done pulses on the same edge as the last step, with the final result
`timescale 1ns/1ps
module wdu_core (
  input  wire logic        clk_in,       // Clock
  input  wire logic        rst_in,       // Synchronous reset
  input  wire logic        ce_in,        // Clock enable
  input  wire logic        start_in,     // Start pulse
  input  wire logic [31:0] dvd_in,       // Unsigned dividend
  input  wire logic [31:0] dvs_in,       // Unsigned divisor
  output logic             done_out,     // Result valid pulse
  output logic [31:0]      quo_out,      // Quotient
  output logic [31:0]      rem_out       // Remainder
);
  logic [31:0] q_r;                      // Quotient / shifting dividend
  logic [31:0] r_r;                      // Partial remainder
  logic [31:0] d_r;                      // Held divisor
  logic [5:0]  cnt_r;                    // Steps left
  logic        done_r;                   // Done flag
  logic [32:0] trial;                    // Shifted partial remainder
  logic [32:0] diff;                     // Trial subtraction
  ////////////////////////////////////////////////////////////////////////
  // Trial subtraction
  assign trial = {r_r, q_r[31]};
  assign diff  = trial - {1'b0, d_r};
  ////////////////////////////////////////////////////////////////////////
  // Iteration
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      q_r    <= '0;
      r_r    <= '0;
      d_r    <= '0;
      cnt_r  <= '0;
      done_r <= 1'b0;
    end
    else if (ce_in)
    begin
      done_r <= 1'b0;
      if (start_in)
      begin
        // Load operands
        q_r   <= dvd_in;
        r_r   <= '0;
        d_r   <= dvs_in;
        cnt_r <= wdu_pkg::STEPS;
      end
      else if (cnt_r != '0)
      begin
        // Keep or restore
        if (!diff[32])
          r_r <= diff[31:0];
        else
          r_r <= trial[31:0];
        q_r    <= {q_r[30:0], ~diff[32]};
        cnt_r  <= cnt_r - wdu_pkg::CNT_ONE;
        done_r <= (cnt_r == wdu_pkg::CNT_ONE);
      end
    end
  end
  assign done_out = done_r;
  assign quo_out  = q_r;
  assign rem_out  = r_r;
endmodule

// file: wdu_issue_model.sv
// Purpose: Issue logic and register file side facing the divide unit
// Assumes: One divide or illegal issue in flight at a time
// Notes:   Keeps the summary flag and the last value of every write
`timescale 1ns/1ps
module wdu_issue_model (
  input  wire logic        clk_in,      // Core clock
  input  wire logic        illegal_in,  // Non-divide issue pulse
  input  wire logic        tgt_we_in,   // Target write pulse
  input  wire logic [4:0]  tgt_sel_in,  // Target register field
  input  wire logic [31:0] tgt_data_in, // Quotient
  input  wire logic        rem_we_in,   // Remainder register write
  input  wire logic [31:0] rem_data_in, // Remainder
  input  wire logic        xer_we_in,   // Flag write pulse
  input  wire logic        so_new_in,   // New summary overflow
  input  wire logic        ov_new_in,   // New overflow flag
  input  wire logic        cr0_we_in,   // Condition field write
  input  wire logic [3:0]  cr0_in,      // lt,gt,eq,so
  output logic             issue_out,   // Instruction valid
  output logic [31:0]      instr_out,   // Instruction word
  output logic [31:0]      src1_out,    // Dividend
  output logic [31:0]      src2_out,    // Divisor
  output logic             cur_so_out   // Current summary overflow
);
  logic        so_r  = 1'b0;   // Summary overflow flag
  logic        ov_r  = 1'b0;   // Overflow flag
  logic [4:0]  sel_r = 5'h00;  // Last target selection
  logic [31:0] tgt_r;          // Last target value
  logic [31:0] rem_r;          // Remainder register
  logic [3:0]  cr_r;           // Condition field 0
  int          n_tgt = 0;      // Write and illegal pulse counts
  int          n_rem = 0;
  int          n_xer = 0;
  int          n_cr  = 0;
  int          n_ill = 0;

  initial issue_out = 1'b0;
  initial instr_out = 32'h00000000;
  initial src1_out  = 32'h00000000;
  initial src2_out  = 32'h00000000;
  assign cur_so_out = so_r;

  ////////////////////////////////////////////////////////////////////////
  // Capture every write the unit makes
  always_ff @(posedge clk_in)
  begin
    if (tgt_we_in)
    begin
      n_tgt <= n_tgt + 1;
      sel_r <= tgt_sel_in;
      tgt_r <= tgt_data_in;
    end
    if (rem_we_in)
    begin
      n_rem <= n_rem + 1;
      rem_r <= rem_data_in;
    end
    if (xer_we_in)
    begin
      n_xer <= n_xer + 1;
      so_r  <= so_new_in;
      ov_r  <= ov_new_in;
    end
    if (cr0_we_in)
    begin
      n_cr <= n_cr + 1;
      cr_r <= cr0_in;
    end
    if (illegal_in)
      n_ill <= n_ill + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Issue one instruction, optionally a refused repeat, await its answer
  task automatic run(input logic [31:0] instr, input logic [31:0] a,
                     input logic [31:0] b, input bit dup, output bit ok);
    int k;
    int t0;
    int i0;
    t0 = n_tgt;
    i0 = n_ill;
    ok = 1'b0;
    @(posedge clk_in);
    issue_out <= 1'b1;
    instr_out <= instr;
    src1_out  <= a;
    src2_out  <= b;
    for (k = 0; k < 60; k++)
    begin
      @(posedge clk_in);
      issue_out <= dup && (k == 4);  // Repeat lands while busy
      #1;
      if (n_tgt != t0 || n_ill != i0)
      begin
        ok = 1'b1;
        break;
      end
    end
  endtask
endmodule

// file: tb_word_integer_divide_unit.sv
// Purpose: Self-checking bench for the word integer divide unit
// Assumes: Clock enable drops once, in the middle of one divide
// Notes:   Undefined overflow results are not compared
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_word_integer_divide_unit;
  logic        CLK_IN = 1'b0;      // 10 MHz clock
  logic        SYS_RST_IN = 1'b1;  // Reset
  logic        CE_IN = 1'b1;       // Enabled except for one four-edge freeze
  logic        issue, ill, twe, rwe, xwe, so_n, ov_n, cwe, so_c, busy;
  logic [31:0] instr, s1, s2, tdat, rdat;
  logic [4:0]  tsel;
  logic [3:0]  cr0;
  int          mismatches = 0;     // Failed comparisons
  int          n_checks = 0;       // All comparisons
  logic        exp_so = 1'b0;      // Expected summary overflow
  logic [4:0]  tg = 5'h00;         // Rotating target field

  wdu_top u_dut (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CE_IN(CE_IN),
    .ISSUE_IN(issue), .INSTR_IN(instr), .SRC1_DATA_IN(s1),
    .SRC2_DATA_IN(s2), .SO_IN(so_c), .BUSY_OUT(busy), .ILLEGAL_OUT(ill),
    .TGT_WE_OUT(twe), .TGT_SEL_OUT(tsel), .TGT_DATA_OUT(tdat),
    .REM_WE_OUT(rwe), .REM_DATA_OUT(rdat), .XER_WE_OUT(xwe),
    .SO_OUT(so_n), .OV_OUT(ov_n), .CR0_WE_OUT(cwe), .CR0_OUT(cr0));
  wdu_issue_model u_model (.clk_in(CLK_IN), .illegal_in(ill),
    .tgt_we_in(twe), .tgt_sel_in(tsel), .tgt_data_in(tdat),
    .rem_we_in(rwe), .rem_data_in(rdat), .xer_we_in(xwe),
    .so_new_in(so_n), .ov_new_in(ov_n), .cr0_we_in(cwe), .cr0_in(cr0),
    .issue_out(issue), .instr_out(instr), .src1_out(s1), .src2_out(s2),
    .cur_so_out(so_c));

  initial forever #50 CLK_IN = ~CLK_IN;

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Instruction word, bit 0 of the word at the top
  function automatic logic [31:0] enc(input logic [8:0] ext,
                                      input logic oe, input logic rc);
    return {wdu_pkg::PRIM_OP, tg, 5'h03, 5'h04, oe, ext, rc};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // One divide with all its expected writes
  task automatic div(input logic [8:0] ext, input logic oe, input logic rc,
                     input logic [31:0] a, input logic [31:0] b,
                     input bit dup);
    logic [31:0] q, r;
    logic        ov, leg, def;
    int          r0, x0, c0;
    bit          ok;
    leg = (ext == wdu_pkg::EXT_LEGACY);
    ov = (b == 32'h00000000) || (ext != wdu_pkg::EXT_UNSIGNED &&
         a == wdu_pkg::MOST_NEG && b == wdu_pkg::MINUS_ONE);
    def = !ov || (leg && b != 32'h00000000);
    if (ov)
    begin
      q = wdu_pkg::MOST_NEG;
      r = 32'h00000000;
    end
    else if (ext == wdu_pkg::EXT_UNSIGNED)
    begin
      q = a / b;
      r = a % b;
    end
    else
    begin
      q = $signed(a) / $signed(b);
      r = $signed(a) % $signed(b);
    end
    if (oe)
      exp_so = exp_so | ov;
    tg = tg + 5'h05;
    r0 = u_model.n_rem;
    x0 = u_model.n_xer;
    c0 = u_model.n_cr;
    u_model.run(enc(ext, oe, rc), a, b, dup, ok);
    if (!ok)
    begin
      mismatches++;
      stop_test();
    end
    `CHK("busy", 1'b0, busy)
    `CHK("target field", tg, u_model.sel_r)
    if (def)
      `CHK("quotient", q, u_model.tgt_r)
    if (leg && def)
      `CHK("remainder", r, u_model.rem_r)
    `CHK("rem writes", int'(leg), u_model.n_rem - r0)
    `CHK("flag writes", int'(oe), u_model.n_xer - x0)
    if (oe)
      `CHK("overflow", ov, u_model.ov_r)
    `CHK("summary", exp_so, u_model.so_r)
    `CHK("cr writes", int'(rc), u_model.n_cr - c0)
    if (rc)
      `CHK("cr summary", exp_so, u_model.cr_r[0])
    if (rc && def)
      `CHK("cr compare", {q[31], !q[31] && q != 0, q == 0},
           u_model.cr_r[3:1])
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin : main
    logic [8:0] lg, sg, ug;
    int         i0;
    bit         ok;
    lg = wdu_pkg::EXT_LEGACY;
    sg = wdu_pkg::EXT_SIGNED;
    ug = wdu_pkg::EXT_UNSIGNED;
    repeat (5) @(posedge CLK_IN);
    SYS_RST_IN <= 1'b0;
    div(lg, 1'b1, 1'b1, 32'h00000007, 32'hFFFFFFFE, 1'b1);
    div(lg, 1'b0, 1'b1, 32'hFFFFFFF9, 32'h00000002, 1'b0);
    div(lg, 1'b0, 1'b0, 32'hFFFFFFFC, 32'h00000002, 1'b0);
    div(lg, 1'b1, 1'b1, 32'h80000000, 32'hFFFFFFFF, 1'b0);
    div(lg, 1'b1, 1'b0, 32'h00000001, 32'h00000000, 1'b0);
    div(sg, 1'b1, 1'b1, 32'h80000000, 32'hFFFFFFFF, 1'b0);
    // Freeze the unit for four edges while this divide runs
    fork
    begin
      repeat (6) @(posedge CLK_IN);
      CE_IN <= 1'b0;
      #1 `CHK("busy held", 1'b1, busy)
      repeat (4) @(posedge CLK_IN);
      CE_IN <= 1'b1;
    end
    join_none
    div(sg, 1'b1, 1'b0, 32'hFFFFFFF7, 32'h00000004, 1'b0);
    div(ug, 1'b0, 1'b1, 32'h80000000, 32'h00000002, 1'b0);
    div(ug, 1'b0, 1'b1, 32'hFFFFFFFF, 32'h00000001, 1'b0);
    div(ug, 1'b1, 1'b1, 32'h00000005, 32'h00000000, 1'b0);
    div(ug, 1'b0, 1'b1, 32'h00000003, 32'h00000007, 1'b0);
    i0 = u_model.n_ill;
    u_model.run(enc(9'h108, 1'b1, 1'b1), 32'h00000001, 32'h00000001,
                1'b0, ok);
    `CHK("illegal", 1, u_model.n_ill - i0)
    `CHK("target writes", 11, u_model.n_tgt)
    stop_test();
  end
endmodule
